// ==== src/ssr_top.sv ====
// Serial-loaded configuration, main divider and double-buffered reference registers
`include "ssr_map.svh"
module ssr_top
  import ssr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_ser_en_b,
  input wire logic i_reference_input,
  output logic [`SSR_CFG_W-1:0] o_config_q,
  output logic [`SSR_SH_W-1:0] o_main_div_q,
  output logic [`SSR_RLO_W-1:0] o_ref_buf1_q,
  output logic [`SSR_RLO_W-1:0] o_ref_ratio_q,
  output logic [2:0] o_ref_sel_q,
  output logic o_phase_compare_q,
  output logic o_cascade_out_q,
  output logic o_gpo_b_q,
  output logic o_gpo_b_oe_q
);
  ssr_pins_t pins_raw;
  ssr_pins_t lvl;
  ssr_pins_t prev_q;
  logic [3:0] lvl_vec;
  ssr_state_t state_q;
  ssr_state_t state_d;
  logic [`SSR_CNT_W-1:0] cnt_q;
  logic [`SSR_SH_W-1:0] sh_q;
  logic clk_low_q;
  logic [`SSR_RLO_W-1:0] ref_cnt_q;

  function automatic logic len_legal(input logic [`SSR_CNT_W-1:0] n);
    len_legal = (n == `SSR_LEN_CFG) || (n == `SSR_LEN_REF) || (n == `SSR_LEN_MAIN);
  endfunction : len_legal

  assign pins_raw = '{ser_clk: i_ser_clk, ser_data: i_ser_data, ser_en_b: i_ser_en_b,
                      ref_in: i_reference_input};

  // Enable idles high; a low reset level would fake a frame after reset
  ssr_sync #(.W(4), .RST(4'h2)) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async(pins_raw),
    .o_level(lvl_vec)
  );
  assign lvl = lvl_vec;

  wire en_act = ~lvl.ser_en_b;
  wire clk_rise = lvl.ser_clk & ~prev_q.ser_clk;
  wire ref_rise = lvl.ref_in & ~prev_q.ref_in;
  wire en_start = (state_q == SSR_IDLE) & en_act;
  wire en_end = (state_q == SSR_SHIFT) & ~en_act;
  wire shift_now = (state_q == SSR_SHIFT) & en_act & clk_rise;
  wire load_cfg = en_end & (cnt_q == `SSR_LEN_CFG);
  wire load_ref = en_end & (cnt_q == `SSR_LEN_REF);
  wire load_main = en_end & (cnt_q == `SSR_LEN_MAIN);
  // A clockless pulse only commits when the clock stayed low all along
  wire commit = en_end & (cnt_q == `SSR_LEN_COMMIT) & clk_low_q;
  wire ref_term = ref_rise & (ref_cnt_q <= `SSR_RLO_W'(1));

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SSR_IDLE: if (en_act) state_d = SSR_SHIFT;
      SSR_SHIFT: if (!en_act) state_d = SSR_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= SSR_IDLE;
      prev_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      prev_q <= lvl;
    end
  end

  // Edge counting saturates so overlong frames can never alias a legal length
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      cnt_q <= '0;
    else if (en_start)
      cnt_q <= '0;
    else if (shift_now && cnt_q != `SSR_CNT_MAX)
      cnt_q <= cnt_q + `SSR_CNT_W'(1);
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sh_q <= '0;
      o_cascade_out_q <= 1'b0;
    end
    else if (shift_now)
    begin
      sh_q <= {sh_q[`SSR_SH_W-2:0], lvl.ser_data};
      o_cascade_out_q <= sh_q[`SSR_SH_W-1];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      clk_low_q <= 1'b0;
    else if (en_start)
      clk_low_q <= ~lvl.ser_clk;
    else if (lvl.ser_clk)
      clk_low_q <= 1'b0;
  end

  // Any other count at enable end falls through with no load, except a count of 0 with clock low, which commits the ratio
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_config_q <= `SSR_CFG_RST;
      o_main_div_q <= `SSR_MAIN_RST;
      o_ref_buf1_q <= `SSR_RLO_RST;
      o_ref_ratio_q <= `SSR_RLO_RST;
      o_ref_sel_q <= `SSR_RSEL_RST;
    end
    else
    begin
      if (load_cfg)
        o_config_q <= sh_q[`SSR_CFG_W-1:0];
      if (load_main)
        o_main_div_q <= sh_q;
      if (load_ref)
      begin
        o_ref_sel_q <= sh_q[`SSR_RSEL_MSB:`SSR_RSEL_LSB];
        o_ref_buf1_q <= sh_q[`SSR_RLO_MSB:0];
      end
      if (load_main || commit)
        o_ref_ratio_q <= o_ref_buf1_q;
    end
  end

  // Reload only at terminal count, so a new ratio waits out the cycle in flight
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ref_cnt_q <= `SSR_RLO_RST;
      o_phase_compare_q <= 1'b0;
    end
    else
    begin
      o_phase_compare_q <= ref_term;
      if (ref_term)
        ref_cnt_q <= o_ref_ratio_q;
      else if (ref_rise)
        ref_cnt_q <= ref_cnt_q - `SSR_RLO_W'(1);
    end
  end

  // Pin level is fixed low; enable sinks the front-end supply switch in standby
  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_gpo_b_q <= 1'b0;
      o_gpo_b_oe_q <= 1'b0;
    end
    else
    begin
      o_gpo_b_q <= 1'b0;
      o_gpo_b_oe_q <= o_config_q[`SSR_CFG_STBY_BIT];
    end
  end

  property p_cfg_load;
    @(posedge i_clock) disable iff (!i_rst_b)
    load_cfg |=> o_config_q == $past(sh_q[7:0]) && $stable(o_main_div_q) && $stable(o_ref_buf1_q);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config load wrong");

  property p_main_load;
    @(posedge i_clock) disable iff (!i_rst_b)
    load_main |=> o_main_div_q == $past(sh_q);
  endproperty
  a_main_load: assert property (p_main_load) else $error("main load wrong");

  property p_main_commit;
    @(posedge i_clock) disable iff (!i_rst_b)
    load_main |=> o_ref_ratio_q == $past(o_ref_buf1_q);
  endproperty
  a_main_commit: assert property (p_main_commit) else $error("ratio not committed");

  property p_main_keeps;
    @(posedge i_clock) disable iff (!i_rst_b)
    load_main |=> $stable(o_ref_buf1_q) && $stable(o_config_q);
  endproperty
  a_main_keeps: assert property (p_main_keeps) else $error("main load disturbed");

  property p_ref_sel;
    @(posedge i_clock) disable iff (!i_rst_b)
    load_ref |=> o_ref_sel_q == $past(sh_q[15:13]);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("ref select wrong");

  property p_ref_buf;
    @(posedge i_clock) disable iff (!i_rst_b)
    load_ref |=> o_ref_buf1_q == $past(sh_q[12:0]) && $stable(o_ref_ratio_q)
      && $stable(o_config_q) && $stable(o_main_div_q);
  endproperty
  a_ref_buf: assert property (p_ref_buf) else $error("ref buffer wrong");

  property p_commit;
    @(posedge i_clock) disable iff (!i_rst_b)
    commit |=> o_ref_ratio_q == $past(o_ref_buf1_q) && $stable(o_ref_buf1_q)
      && $stable(o_config_q) && $stable(o_main_div_q);
  endproperty
  a_commit: assert property (p_commit) else $error("commit wrong");

  property p_ref_finish;
    @(posedge i_clock) disable iff (!i_rst_b)
    ref_rise && ref_cnt_q > 13'h0001 |=> ref_cnt_q == $past(ref_cnt_q) - 13'h0001;
  endproperty
  a_ref_finish: assert property (p_ref_finish) else $error("ref count cut short");

  property p_standby;
    @(posedge i_clock) disable iff (!i_rst_b)
    o_config_q[0] ##1 o_config_q[0] |-> o_gpo_b_oe_q && !o_gpo_b_q;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not driven");

  property p_count;
    @(posedge i_clock) disable iff (!i_rst_b)
    shift_now && cnt_q != 5'h1F |=> cnt_q == $past(cnt_q) + 5'h01;
  endproperty
  a_count: assert property (p_count) else $error("edge count wrong");

  property p_discard;
    @(posedge i_clock) disable iff (!i_rst_b)
    en_end && !len_legal(cnt_q) && !commit |=> $stable(o_config_q) && $stable(o_main_div_q)
      && $stable(o_ref_buf1_q) && $stable(o_ref_ratio_q) && $stable(o_ref_sel_q);
  endproperty
  a_discard: assert property (p_discard) else $error("bad frame loaded");
endmodule : ssr_top

// ==== src/ssr_map.svh ====
// Constants for the serial register load block: lengths, field positions, reset values
//Function
//- Configuration-length transfer end latches shifted byte into configuration register only.
//- Main-divider-length transfer end stores the new bytes into main divider register.
//- Main divider load also copies reference first buffer low bits into second buffer.
//- Main divider load leaves reference first buffer and configuration register untouched.
//- Reference-length transfer stores top three bits directly as reference output select.
//- Reference-length transfer puts low thirteen bits only into first buffer.
//- Clockless enable pulse with serial clock low copies first buffer to second.
//- Reference counter finishes its current count before using a new ratio.
//- Open-drain general output can switch off the front end for standby.
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
`define SSR_CNT_W 5
`define SSR_CNT_MAX 5'h1F
`define SSR_LEN_CFG 5'h08
`define SSR_LEN_REF 5'h10
`define SSR_LEN_MAIN 5'h18
`define SSR_LEN_COMMIT 5'h00
`define SSR_SH_W 24
`define SSR_CFG_W 8
`define SSR_RLO_W 13
`define SSR_RSEL_MSB 15
`define SSR_RSEL_LSB 13
`define SSR_RLO_MSB 12
`define SSR_CFG_STBY_BIT 0
`define SSR_CFG_RST 8'h00
`define SSR_MAIN_RST 24'h00_0000
`define SSR_RLO_RST 13'h0001
`define SSR_RSEL_RST 3'h0
`endif

// ==== src/ssr_pkg.sv ====
// Types shared by the serial register load block
package ssr_pkg;
  typedef struct packed {
    logic ser_clk;
    logic ser_data;
    logic ser_en_b;
    logic ref_in;
  } ssr_pins_t;

  typedef enum logic [1:0] {
    SSR_IDLE = 2'h1,
    SSR_SHIFT = 2'h2
  } ssr_state_t;
endpackage : ssr_pkg

// ==== src/ssr_sync.sv ====
// Three-stage pin synchroniser with agreement filter
module ssr_sync #(
  parameter int W = 4,
  // Idle level of each pin, so release of reset shows no false edge
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] ff1_q;
  logic [W-1:0] ff2_q;
  logic [W-1:0] ff3_q;
  logic [W-1:0] lvl_d;

  // Only agreeing late stages move the level; first stage feeds stage two alone
  assign lvl_d = (ff2_q & ff3_q) | (o_level & (ff2_q | ff3_q));

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ff1_q <= RST;
      ff2_q <= RST;
      ff3_q <= RST;
      o_level <= RST;
    end
    else
    begin
      ff1_q <= i_async;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      o_level <= lvl_d;
    end
  end
endmodule : ssr_sync

// ==== tb/ssr_host.sv ====
// Host serial master model driving the serial pins
module ssr_host (
  input wire logic i_clock,
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_ser_en_b
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_en_b = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge i_clock);
  endtask : hold
  // Called at a falling edge; ph sets the speed of each clock phase
  task automatic send(input logic [23:0] v, input int n, input int ph);
    o_ser_en_b = 1'b0;
    hold(ph);
    for (int i = n - 1; i >= 0; i--)
    begin
      o_ser_data = v[i];
      hold(ph);
      o_ser_clk = 1'b1;
      hold(ph);
      o_ser_clk = 1'b0;
    end
    hold(ph);
    o_ser_en_b = 1'b1;
    // No pull on data: show the inverse once released
    o_ser_data = ~o_ser_data;
    hold(12);
  endtask : send
  // Fifteen clocks, clock left high past enable end
  task automatic init_seq(input int ph);
    o_ser_en_b = 1'b0;
    hold(ph);
    for (int i = 0; i < 15; i++)
    begin
      o_ser_clk = 1'b0;
      hold(ph);
      o_ser_clk = 1'b1;
      hold(ph);
    end
    o_ser_en_b = 1'b1;
    hold(26);
    o_ser_clk = 1'b0;
    hold(12);
  endtask : init_seq
  // Clock kept low for the whole pulse
  task automatic commit(input int ph);
    o_ser_en_b = 1'b0;
    hold(ph);
    o_ser_en_b = 1'b1;
    hold(12);
  endtask : commit
endmodule : ssr_host

// ==== tb/tb_ssr_top.sv ====
// Self-checking bench for the serial register load block
`include "ssr_map.svh"
module tb_ssr_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock;
  logic i_rst_b;
  logic i_ser_clk;
  logic i_ser_data;
  logic i_ser_en_b;
  logic i_reference_input;
  logic [`SSR_CFG_W-1:0] o_config_q;
  logic [`SSR_SH_W-1:0] o_main_div_q;
  logic [`SSR_RLO_W-1:0] o_ref_buf1_q;
  logic [`SSR_RLO_W-1:0] o_ref_ratio_q;
  logic [2:0] o_ref_sel_q;
  logic o_phase_compare_q;
  logic o_cascade_out_q;
  logic o_gpo_b_q;
  logic o_gpo_b_oe_q;
  int err_count;
  int tests_run;
  int n;
  ssr_host i_host (.i_clock(i_clock), .o_ser_clk(i_ser_clk), .o_ser_data(i_ser_data),
    .o_ser_en_b(i_ser_en_b));
  ssr_top i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ser_clk(i_ser_clk),
    .i_ser_data(i_ser_data), .i_ser_en_b(i_ser_en_b), .i_reference_input(i_reference_input),
    .o_config_q(o_config_q), .o_main_div_q(o_main_div_q), .o_ref_buf1_q(o_ref_buf1_q),
    .o_ref_ratio_q(o_ref_ratio_q), .o_ref_sel_q(o_ref_sel_q),
    .o_phase_compare_q(o_phase_compare_q), .o_cascade_out_q(o_cascade_out_q),
    .o_gpo_b_q(o_gpo_b_q),
    .o_gpo_b_oe_q(o_gpo_b_oe_q));
  always #2 i_clock = ~i_clock;
  // Reference period of 16 system cycles
  always
  begin
    repeat (8) @(negedge i_clock);
    i_reference_input = ~i_reference_input;
  end
  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic chk_all(input logic [7:0] c, input logic [23:0] m, input logic [12:0] b1,
    input logic [12:0] r, input logic [2:0] s);
    check(o_config_q, c);
    check(o_main_div_q, m);
    check(o_ref_buf1_q, b1);
    check(o_ref_ratio_q, r);
    check(o_ref_sel_q, s);
  endtask : chk_all
  // Cycles between two phase compare pulses, less one
  task automatic meas(output int q);
    int k;
    k = 0;
    q = 0;
    while (o_phase_compare_q !== 1'b1 && k < 4000)
    begin
      @(negedge i_clock);
      k++;
    end
    @(negedge i_clock);
    while (o_phase_compare_q !== 1'b1 && q < 4000)
    begin
      @(negedge i_clock);
      q++;
    end
    if (k >= 4000 || q >= 4000)
    begin
      err_count++;
      close_out();
    end
  endtask : meas
  initial
  begin
    i_clock = 1'b0;
    i_rst_b = 1'b0;
    i_reference_input = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clock);
    chk_all(8'h00, 24'h00_0000, 13'h0001, 13'h0001, 3'h0);
    check(o_gpo_b_oe_q, 1'b0);
    $display("reset test done");
    i_host.send(24'h00_00A5, 8, 4);
    chk_all(8'hA5, 24'h00_0000, 13'h0001, 13'h0001, 3'h0);
    check(o_gpo_b_oe_q, 1'b1);
    check(o_gpo_b_q, 1'b0);
    $display("config test done");
    // Slow host; ratio chosen as reference over compare rate
    i_host.send(24'h00_E00A, 16, 10);
    chk_all(8'hA5, 24'h00_0000, 13'h000A, 13'h0001, 3'h7);
    meas(n);
    meas(n);
    check(n + 1, 24'h00_0010);
    i_host.commit(6);
    chk_all(8'hA5, 24'h00_0000, 13'h000A, 13'h000A, 3'h7);
    meas(n);
    meas(n);
    check(n + 1, 24'h00_00A0);
    $display("reference test done");
    i_host.send(24'h00_2005, 16, 4);
    chk_all(8'hA5, 24'h00_0000, 13'h0005, 13'h000A, 3'h1);
    // Main count and swallow packed as one feedback word
    i_host.send(24'h12_3456, 24, 4);
    chk_all(8'hA5, 24'h12_3456, 13'h0005, 13'h0005, 3'h1);
    // Chained data: last bit out is bit 0 of the previous frame
    check(o_cascade_out_q, 1'b1);
    meas(n);
    meas(n);
    check(n + 1, 24'h00_0050);
    $display("main test done");
    i_host.send(24'h7F_FFFF, 15, 4);
    check(o_cascade_out_q, 1'b0);
    i_host.send(24'h00_0FFF, 12, 4);
    chk_all(8'hA5, 24'h12_3456, 13'h0005, 13'h0005, 3'h1);
    i_host.init_seq(4);
    chk_all(8'hA5, 24'h12_3456, 13'h0005, 13'h0005, 3'h1);
    i_host.send(24'h00_0000, 8, 4);
    check(o_gpo_b_oe_q, 1'b0);
    chk_all(8'h00, 24'h12_3456, 13'h0005, 13'h0005, 3'h1);
    $display("discard test done");
    close_out();
  end
endmodule : tb_ssr_top
